// ===== verilog/wdnv_cfg.svh
`ifndef WDNV_CFG_SVH
`define WDNV_CFG_SVH
// local bus offsets
`define WDNV_OFF_CHIP 17'h0_8000
`define WDNV_OFF_CMD 17'h0_800B
`define WDNV_OFF_TMO_LO 17'h0_800C
`define WDNV_OFF_TMO_HI 17'h0_800D
`define WDNV_OFF_RAM_LO 17'h0_800E
`define WDNV_OFF_RAM_HI 17'h1_000D
`define WDNV_OFF_BCTL 17'h0_0010
// timekeeping command fields
`define WDNV_CMD_FLAG 1
`define WDNV_CMD_DIS 4
`define WDNV_CMD_PULSE 5
`define WDNV_CMD_SEL 6
`define WDNV_CMD_XFER 7
`define WDNV_CMD_RW_MASK 8'hF0
`define WDNV_CMD_RST 8'h10
// board control fields
`define WDNV_BCTL_WDEN 0
`define WDNV_BCTL_RST 8'h00
`define WDNV_TMO_RST 8'h00
// timing
`define WDNV_CLK_NS 40
`define WDNV_TICK_NS 10000000
`define WDNV_PULSE_NS 200
`define WDNV_RAM_AW 15
`endif

// ===== verilog/wdnv_pkg.sv
`default_nettype none
package wdnv_pkg;
	typedef struct packed {
		logic cs;
		logic we;
		logic [16:0] addr;
		logic [7:0] wdata;
	} wdnv_req_s;
	typedef enum logic [2:0] {
		WD_IDLE = 3'h1,
		WD_COUNT = 3'h2,
		WD_FIRE = 3'h4
	} wdnv_state_e;
endpackage
`default_nettype wire

// ===== verilog/wdnv_ram.sv
`timescale 1ns/1ps
`default_nettype none
module wdnv_ram #(
	parameter int AW = 15,
	parameter int DW = 8
) (
	// clock
	input wire logic mclk,
	input wire logic ce,
	// access port
	input wire logic we,
	input wire logic [AW-1:0] addr,
	input wire logic [DW-1:0] wdata,
	output logic [DW-1:0] rdata
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	// no reset: contents are meant to survive a board reset
	always_ff @(posedge mclk) begin
		if (ce) begin
			if (we) begin
				mem[addr] <= wdata;
			end
			rdata <= mem[addr];
		end
	end
endmodule
`default_nettype wire

// ===== verilog/wdnv_top.sv
`include "wdnv_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module wdnv_top #(
	parameter int TICK_CYCLES = `WDNV_TICK_NS / `WDNV_CLK_NS,
	parameter int PULSE_CYCLES = (`WDNV_PULSE_NS + `WDNV_CLK_NS - 1) / `WDNV_CLK_NS
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic ce,
	// local bus
	input wire wdnv_pkg::wdnv_req_s req,
	output logic ack,
	output logic [7:0] rdata,
	// watchdog lines
	output logic wdog_irq_a,
	output logic wdog_irq_b,
	output logic board_reset_req
);
	logic [7:0] timekeeping_command;
	logic [7:0] watchdog_timeout_low;
	logic [7:0] watchdog_timeout_high;
	logic [7:0] board_control_register;
	wdnv_pkg::wdnv_state_e state;
	logic [13:0] cnt;
	logic [31:0] tick;
	logic [31:0] pulse_cnt;
	logic p1_vld;
	logic p1_mem;
	logic [7:0] p1_reg;
	logic [7:0] reg_rd;
	logic [7:0] ram_q;
	logic ram_hit;
	logic [16:0] ram_off;
	logic cmd_wr;
	logic tmo_wr;
	logic ext_en;
	logic active;
	logic pulse_mode;
	logic fire_evt;
	logic tick_hit;
	logic [13:0] load;
	logic wd_out;

	function automatic logic [13:0] bcd_ticks(input logic [7:0] hi, input logic [7:0] lo);
		logic [13:0] v;
		v = 14'(hi[7:4]) * 14'd1000 + 14'(hi[3:0]) * 14'd100;
		v = v + 14'(lo[7:4]) * 14'd10 + 14'(lo[3:0]);
		return v;
	endfunction

	assign cmd_wr = req.cs && req.we && req.addr == `WDNV_OFF_CMD;
	assign tmo_wr = req.cs && req.we &&
		(req.addr == `WDNV_OFF_TMO_LO || req.addr == `WDNV_OFF_TMO_HI);
	assign ext_en = board_control_register[`WDNV_BCTL_WDEN];
	assign active = !timekeeping_command[`WDNV_CMD_DIS] && ext_en;
	assign pulse_mode = timekeeping_command[`WDNV_CMD_PULSE];
	assign load = bcd_ticks(watchdog_timeout_high, watchdog_timeout_low);
	assign tick_hit = tick == 32'(TICK_CYCLES - 1);
	assign fire_evt = state == wdnv_pkg::WD_COUNT && active && !tmo_wr && tick_hit &&
		cnt == 14'd1;
	assign ram_hit = req.addr >= `WDNV_OFF_RAM_LO && req.addr <= `WDNV_OFF_RAM_HI;
	assign ram_off = req.addr - `WDNV_OFF_CHIP;

	// control registers
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			board_control_register <= `WDNV_BCTL_RST;
		end else if (ce && req.cs && req.we && req.addr == `WDNV_OFF_BCTL) begin
			board_control_register <= req.wdata;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			timekeeping_command <= `WDNV_CMD_RST;
		end else if (ce) begin
			if (cmd_wr) begin
				timekeeping_command[7:4] <= req.wdata[7:4];
			end
			// a timeout in the clearing cycle keeps the flag set
			if (fire_evt) begin
				timekeeping_command[`WDNV_CMD_FLAG] <= 1'b1;
			end else if (cmd_wr && !req.wdata[`WDNV_CMD_FLAG]) begin
				timekeeping_command[`WDNV_CMD_FLAG] <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			watchdog_timeout_low <= `WDNV_TMO_RST;
			watchdog_timeout_high <= `WDNV_TMO_RST;
		end else if (ce && tmo_wr) begin
			if (req.addr == `WDNV_OFF_TMO_LO) begin
				watchdog_timeout_low <= req.wdata;
			end else begin
				watchdog_timeout_high <= req.wdata;
			end
		end
	end

	// watchdog sequencer; a timeout write restarts the count
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			state <= wdnv_pkg::WD_IDLE;
			cnt <= 14'd0;
			tick <= 32'd0;
			pulse_cnt <= 32'd0;
		end else if (ce) begin
			tick <= (tick_hit || state != wdnv_pkg::WD_COUNT || tmo_wr) ? 32'd0 : tick + 32'd1;
			case (state)
				wdnv_pkg::WD_IDLE: begin
					if (active && load != 14'd0) begin
						state <= wdnv_pkg::WD_COUNT;
						cnt <= load;
					end
				end
				wdnv_pkg::WD_COUNT: begin
					if (!active) begin
						state <= wdnv_pkg::WD_IDLE;
					end else if (tmo_wr) begin
						state <= wdnv_pkg::WD_IDLE;
					end else if (fire_evt) begin
						state <= wdnv_pkg::WD_FIRE;
						pulse_cnt <= 32'd0;
					end else if (tick_hit) begin
						cnt <= cnt - 14'd1;
					end
				end
				wdnv_pkg::WD_FIRE: begin
					pulse_cnt <= pulse_cnt + 32'd1;
					if (!active) begin
						state <= wdnv_pkg::WD_IDLE;
					end else if (pulse_mode) begin
						if (pulse_cnt == 32'(PULSE_CYCLES - 1)) begin
							state <= wdnv_pkg::WD_IDLE;
						end
					end else if (!timekeeping_command[`WDNV_CMD_FLAG]) begin
						state <= wdnv_pkg::WD_IDLE;
					end
				end
				default: begin
					state <= wdnv_pkg::WD_IDLE;
				end
			endcase
		end
	end

	assign wd_out = state == wdnv_pkg::WD_FIRE;

	// level mode could hold the board in reset forever, hence the gate
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			wdog_irq_a <= 1'b0;
			wdog_irq_b <= 1'b0;
			board_reset_req <= 1'b0;
		end else if (ce) begin
			wdog_irq_a <= wd_out && !timekeeping_command[`WDNV_CMD_SEL];
			wdog_irq_b <= wd_out && timekeeping_command[`WDNV_CMD_SEL];
			board_reset_req <= wd_out && !timekeeping_command[`WDNV_CMD_SEL] && ext_en;
		end
	end

	// register read mux; time-of-day bytes and gaps read zero
	always_comb begin
		reg_rd = 8'h00;
		case (req.addr)
			`WDNV_OFF_CMD: reg_rd = timekeeping_command & (`WDNV_CMD_RW_MASK |
				(8'h01 << `WDNV_CMD_FLAG));
			`WDNV_OFF_TMO_LO: reg_rd = watchdog_timeout_low;
			`WDNV_OFF_TMO_HI: reg_rd = watchdog_timeout_high;
			`WDNV_OFF_BCTL: reg_rd = board_control_register;
			default: reg_rd = 8'h00;
		endcase
	end

	wdnv_ram #(
		.AW(`WDNV_RAM_AW),
		.DW(8)
	) u_ram (
		.mclk(mclk),
		.ce(ce),
		.we(req.cs && req.we && ram_hit),
		.addr(ram_off[`WDNV_RAM_AW-1:0]),
		.wdata(req.wdata),
		.rdata(ram_q)
	);

	// two-stage answer so rdata leaves a flop
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			p1_vld <= 1'b0;
			p1_mem <= 1'b0;
			p1_reg <= 8'h00;
			ack <= 1'b0;
			rdata <= 8'h00;
		end else if (ce) begin
			p1_vld <= req.cs;
			p1_mem <= ram_hit;
			p1_reg <= reg_rd;
			ack <= p1_vld;
			if (p1_vld) begin
				rdata <= p1_mem ? ram_q : p1_reg;
			end
		end
	end

	chk_reset_gate: assert property (@(posedge mclk) disable iff (!rst_b)
		board_reset_req |-> $past(ext_en)) else $error("reset request without enable");
	chk_enable_reset: assert property (@(posedge mclk)
		$rose(rst_b) |-> !ext_en && !board_reset_req) else $error("enable not cleared");
	chk_gate_idle: assert property (@(posedge mclk) disable iff (!rst_b || !ce)
		!active ##1 ce |-> state == wdnv_pkg::WD_IDLE) else $error("runs while gated");
	chk_cmd_disable: assert property (@(posedge mclk) disable iff (!rst_b || !ce)
		timekeeping_command[`WDNV_CMD_DIS] |=> !fire_evt) else $error("fires disabled");
	chk_pulse_len: assert property (@(posedge mclk) disable iff (!rst_b || !ce)
		fire_evt && pulse_mode && active ##1 (active && pulse_mode && ce)[*5] |=>
		state == wdnv_pkg::WD_IDLE) else $error("pulse length wrong");
	// a flag cleared one cycle earlier legitimately ends the level
	chk_level_hold: assert property (@(posedge mclk) disable iff (!rst_b || !ce)
		state == wdnv_pkg::WD_FIRE && !pulse_mode && active && !cmd_wr &&
		timekeeping_command[`WDNV_CMD_FLAG] |=> state == wdnv_pkg::WD_FIRE)
		else $error("level dropped");
	chk_flag_set: assert property (@(posedge mclk) disable iff (!rst_b || !ce)
		fire_evt |=> timekeeping_command[`WDNV_CMD_FLAG]) else $error("flag not set");
	chk_line_route: assert property (@(posedge mclk) disable iff (!rst_b)
		wdog_irq_b |-> $past(timekeeping_command[`WDNV_CMD_SEL])) else $error("bad line");
	chk_tmo_store: assert property (@(posedge mclk) disable iff (!rst_b || !ce)
		tmo_wr && req.addr == `WDNV_OFF_TMO_LO |=> watchdog_timeout_low == $past(req.wdata))
		else $error("timeout byte lost");
	chk_low_zero: assert property (@(posedge mclk) disable iff (!rst_b || !ce)
		req.cs && req.addr < `WDNV_OFF_CHIP && req.addr != `WDNV_OFF_BCTL ##1 ce ##1 ce |->
		ack && rdata == 8'h00) else $error("unmapped not zero");
	chk_ack_time: assert property (@(posedge mclk) disable iff (!rst_b || !ce)
		req.cs ##1 ce |=> ack) else $error("ack late");

	cov_fire: cover property (@(posedge mclk) fire_evt);
	cov_board_reset: cover property (@(posedge mclk) board_reset_req);
	cov_level: cover property (@(posedge mclk) wd_out && !pulse_mode);
	cov_ram_write: cover property (@(posedge mclk) req.cs && req.we && ram_hit);
endmodule
`default_nettype wire

// ===== testbench/wdnv_host.sv
`timescale 1ns/1ps
`default_nettype none
module wdnv_host (
	// local bus
	input wire logic mclk,
	input wire logic ack,
	input wire logic [7:0] rdata,
	output var wdnv_pkg::wdnv_req_s req
);
	initial req = '0;
	// one byte access; q is unknown if no answer came
	task automatic xfer(input logic we, input logic [16:0] a, input logic [7:0] d,
		output logic [7:0] q);
		int n;
		@(posedge mclk);
		#1 req = {1'b1, we, a, d};
		@(posedge mclk);
		#1 req.cs = 1'b0;
		// released data must not keep looking valid
		req.wdata = ~d;
		n = 0;
		while (ack !== 1'b1 && n < 8) begin
			@(posedge mclk);
			#1 n++;
		end
		q = (ack === 1'b1) ? rdata : 8'hxx;
	endtask
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic mclk;
	logic rst_b;
	logic ce;
	logic ack;
	logic irq_a;
	logic irq_b;
	logic brr;
	logic [7:0] rdata;
	logic [7:0] q;
	wire wdnv_pkg::wdnv_req_s req;
	int errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	int n;
	// short tick keeps a BCD 10 timeout at 80 cycles
	wdnv_top #(.TICK_CYCLES(8)) wdnv_top_inst (.mclk(mclk), .rst_b(rst_b), .ce(ce),
		.req(req), .ack(ack), .rdata(rdata), .wdog_irq_a(irq_a), .wdog_irq_b(irq_b),
		.board_reset_req(brr));
	wdnv_host wdnv_host_inst (.mclk(mclk), .ack(ack), .rdata(rdata), .req(req));
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			results();
		end
	end
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [16:0] a, input logic [7:0] d);
		wdnv_host_inst.xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [16:0] a, input logic [7:0] exp);
		wdnv_host_inst.xfer(1'b0, a, 8'h00, q);
		check(q, exp);
	endtask
	task automatic wait_fire(input logic sel, input int lo, input int hi);
		n = 0;
		while ((sel ? irq_b : irq_a) !== 1'b1 && n < 300) begin
			@(posedge mclk);
			#1 n++;
		end
		check(8'(n >= lo && n <= hi), 8'h01);
	endtask
	task automatic results();
		$display("errors %0d compares %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		ce = 1'b1;
		rst_b = 1'b0;
		repeat (5) @(posedge mclk);
		#1 rst_b = 1'b1;
		rd(17'h0_800B, 8'h10);
		rd(17'h0_800C, 8'h00);
		rd(17'h0_0010, 8'h00);
		rd(17'h0_8000, 8'h00);
		rd(17'h0_0020, 8'h00);
		wr(17'h0_C000, 8'hA5);
		wr(17'h1_000D, 8'h5A);
		rd(17'h0_C000, 8'hA5);
		rd(17'h1_000D, 8'h5A);
		wr(17'h0_800D, 8'h00);
		wr(17'h0_800C, 8'h10);
		wr(17'h0_800B, 8'h20);
		// gate still closed: nothing may fire
		repeat (150) @(posedge mclk);
		#1 check({6'h00, irq_a, brr}, 8'h00);
		wr(17'h0_0010, 8'h01);
		wait_fire(1'b0, 70, 90);
		check({7'h00, brr}, 8'h01);
		n = 0;
		while (irq_a === 1'b1 && n < 50) begin
			@(posedge mclk);
			#1 n++;
		end
		check(8'(n), 8'h05);
		rd(17'h0_800B, 8'h22);
		wr(17'h0_800B, 8'h60);
		wait_fire(1'b1, 60, 90);
		check({6'h00, irq_a, brr}, 8'h00);
		// let the line-B pulse end, or moving the line leaks a cycle onto line A
		repeat (8) @(posedge mclk);
		wr(17'h0_800B, 8'h00);
		wait_fire(1'b0, 60, 90);
		repeat (20) @(posedge mclk);
		#1 check({6'h00, irq_a, brr}, 8'h03);
		// clock enable low: the write is lost and the level stays
		ce = 1'b0;
		wr(17'h0_800B, 8'h10);
		ce = 1'b1;
		check({6'h00, irq_a, brr}, 8'h03);
		wr(17'h0_800B, 8'h10);
		// registered outputs fall one edge after the sequencer drops to idle
		@(posedge mclk);
		#1 check({6'h00, irq_a, brr}, 8'h00);
		@(posedge mclk);
		#1 rst_b = 1'b0;
		repeat (5) @(posedge mclk);
		#1 rst_b = 1'b1;
		rd(17'h0_0010, 8'h00);
		results();
	end
endmodule
`default_nettype wire
